// *** pkg/clk_ctrl_pkg.sv ***
// Constants for the clock source guard and module disable register block
// Overview of operation
// R01: Writes of code 100 to the new clock source field are rejected.
// R02: Fast RC failure forces current clock source to code 100.
// R03: First disable register bit 1 turns the CAN unit off.
// R04: First disable register bit 0 turns the converter unit off.
// R05: Second register bits 11..8 turn capture units 4..1 off.
// R06: Second register bits 3..0 turn compare units 4..1 off.
// R07: Unimplemented disable bit positions always read as zero.
// R08: Every implemented disable bit clears to zero on reset.
package clk_ctrl_pkg;
   localparam int          ADDR_W             = 8;
   localparam logic [7:0]  OSC_CTRL_OFS       = 8'h00;
   localparam logic [7:0]  MOD_OFF_FIRST_OFS  = 8'h04;
   localparam logic [7:0]  MOD_OFF_SECOND_OFS = 8'h08;
   localparam logic [7:0]  IRQ_STATUS_OFS     = 8'h0c;
   localparam logic [7:0]  IRQ_MASK_OFS       = 8'h10;
   localparam int          CUR_SRC_LSB        = 12;
   localparam int          NEW_SRC_LSB        = 8;
   localparam logic [2:0]  SRC_BACKUP_FRC     = 3'h4;
   localparam logic [2:0]  SRC_RESET          = 3'h0;
   localparam int          CAN_OFF_BIT        = 1;
   localparam int          CONV_OFF_BIT       = 0;
   localparam int          CAPTURE_LSB        = 8;
   localparam int          COMPARE_LSB        = 0;
   localparam int          UNITS              = 4;
   localparam logic [15:0] FIRST_MASK         = 16'h0003;
   localparam logic [15:0] SECOND_MASK        = 16'h0f0f;
   localparam logic [15:0] DISABLE_RESET      = 16'h0000;
   localparam int          IRQ_FAIL_BIT       = 0;
   localparam int          IRQ_REJECT_BIT     = 1;
   localparam int          IRQ_W              = 2;
endpackage : clk_ctrl_pkg

// *** hdl/sync2.sv ***
// Two flip-flop synchroniser for a level from another domain
`timescale 1ns/10ps
module sync2 (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Level in and out
   input  wire logic d,
   output logic      q
);
   logic meta_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : sync2

// *** hdl/clock_source_and_module_gating.sv ***
// Wishbone register block: clock source guard and module disables
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module clock_source_and_module_gating (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst,
   // Wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic [31:0]                     wb_dat_o,
   output logic                            wb_ack_o,
   // Oscillator monitor, asynchronous
   input  wire logic                       fast_rc_fail,
   // Module disable outputs
   output logic                            can_unit_off,
   output logic                            converter_unit_off,
   output logic [clk_ctrl_pkg::UNITS-1:0]  capture_units_off,
   output logic [clk_ctrl_pkg::UNITS-1:0]  compare_units_off,
   // Clock source state
   output logic [2:0]                      new_clock_source_select,
   output logic [2:0]                      current_clock_source,
   // Interrupt
   output logic                            irq
);
   import clk_ctrl_pkg::*;

   logic [2:0]       new_src_reg;
   logic [2:0]       cur_src_reg;
   logic [15:0]      first_reg;
   logic [15:0]      second_reg;
   logic [IRQ_W-1:0] status_reg;
   logic [IRQ_W-1:0] status_next;
   logic [IRQ_W-1:0] mask_reg;
   logic             ack_reg;
   logic [31:0]      rdata_reg;
   logic             fail_s;
   logic             fail_d_reg;

   sync2 u_fail_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    (fast_rc_fail),
      .q    (fail_s)
   );

   // Single-cycle answer; ack low for a cycle after each access
   wire        req       = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire        wr        = req & wb_we_i;
   wire        rd        = req & ~wb_we_i;
   wire        lo_en     = wr & wb_sel_i[0];
   wire        hi_en     = wr & wb_sel_i[1];
   wire        sel_osc   = (wb_adr_i == OSC_CTRL_OFS);
   wire        sel_first = (wb_adr_i == MOD_OFF_FIRST_OFS);
   wire        sel_sec   = (wb_adr_i == MOD_OFF_SECOND_OFS);
   wire        sel_stat  = (wb_adr_i == IRQ_STATUS_OFS);
   wire        sel_mask  = (wb_adr_i == IRQ_MASK_OFS);
   wire [2:0]  wr_src    = wb_dat_i[NEW_SRC_LSB+2:NEW_SRC_LSB];
   wire        fail_rise = fail_s & ~fail_d_reg;
   // R01 reject backup code
   wire        src_bad   = hi_en & sel_osc & (wr_src == SRC_BACKUP_FRC);
   wire        src_ok    = hi_en & sel_osc & (wr_src != SRC_BACKUP_FRC);
   wire [15:0] osc_view  = {1'b0, cur_src_reg, 1'b0, new_src_reg, 8'h00};
   wire [15:0] rd_mux    = sel_osc   ? osc_view :
                           sel_first ? first_reg :
                           sel_sec   ? second_reg :
                           sel_stat  ? {14'h0000, status_reg} :
                           sel_mask  ? {14'h0000, mask_reg} : 16'h0000;

   // Set wins over the read-clear
   always_comb begin
      status_next = status_reg;
      if (rd & sel_stat) begin
         status_next = '0;
      end
      if (fail_rise) begin
         status_next[IRQ_FAIL_BIT] = 1'b1;
      end
      if (src_bad) begin
         status_next[IRQ_REJECT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_reg    <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         fail_d_reg <= 1'b0;
         status_reg <= '0;
         mask_reg   <= '0;
      end else begin
         ack_reg    <= req;
         fail_d_reg <= fail_s;
         status_reg <= status_next;
         if (rd) begin
            rdata_reg <= {16'h0000, rd_mux};
         end
         if (lo_en & sel_mask) begin
            mask_reg <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         new_src_reg <= SRC_RESET;
         cur_src_reg <= SRC_RESET;
      end else begin
         // R01 keep prior request
         if (src_ok) begin
            new_src_reg <= wr_src;
         end
         // R02 force backup source
         if (fail_s) begin
            cur_src_reg <= SRC_BACKUP_FRC;
         end else if (src_ok) begin
            cur_src_reg <= wr_src;
         end
      end
   end

   // R08 clear on reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         first_reg  <= DISABLE_RESET;
         second_reg <= DISABLE_RESET;
      end else begin
         // R07 unimplemented bits masked
         if (lo_en & sel_first) begin
            first_reg[7:0] <= wb_dat_i[7:0] & FIRST_MASK[7:0];
         end
         if (hi_en & sel_first) begin
            first_reg[15:8] <= wb_dat_i[15:8] & FIRST_MASK[15:8];
         end
         if (lo_en & sel_sec) begin
            second_reg[7:0] <= wb_dat_i[7:0] & SECOND_MASK[7:0];
         end
         if (hi_en & sel_sec) begin
            second_reg[15:8] <= wb_dat_i[15:8] & SECOND_MASK[15:8];
         end
      end
   end

   // R03 CAN disable
   assign can_unit_off       = first_reg[CAN_OFF_BIT];
   // R04 converter disable
   assign converter_unit_off = first_reg[CONV_OFF_BIT];
   // R05 capture disables
   assign capture_units_off  = second_reg[CAPTURE_LSB+UNITS-1:CAPTURE_LSB];
   // R06 compare disables
   assign compare_units_off  = second_reg[COMPARE_LSB+UNITS-1:COMPARE_LSB];

   assign new_clock_source_select = new_src_reg;
   assign current_clock_source    = cur_src_reg;
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign irq      = |(status_reg & mask_reg);
endmodule : clock_source_and_module_gating

// *** verification/clk_gate_props.sv ***
// Checker for clock guard and module disable block
`timescale 1ns/10ps
module clk_gate_props (
   // Watched ports
   input wire logic        mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic        fast_rc_fail, can_unit_off, converter_unit_off, irq,
   input wire logic [clk_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [clk_ctrl_pkg::UNITS-1:0]  capture_units_off, compare_units_off,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   input wire logic [2:0]  new_clock_source_select, current_clock_source
);
   import clk_ctrl_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   wire wr_a = take && wb_adr_i == MOD_OFF_FIRST_OFS && wb_sel_i[0];
   wire wr_b = take && wb_adr_i == MOD_OFF_SECOND_OFS;
   wire rej  = take && wb_adr_i == OSC_CTRL_OFS && wb_sel_i[1] && wb_dat_i[10:8] == 3'h4;
   ack_answer_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   src_reject_a:
      assert property (rej |=> $stable(new_clock_source_select)) else $error("code taken");
   fail_force_a:
      assert property (fast_rc_fail [*4] |=> current_clock_source == 3'h4) else $error("no fallback");
   first_off_a:
      assert property (wr_a |=> {can_unit_off, converter_unit_off} == $past(wb_dat_i[1:0]))
         else $error("first bits");
   capture_off_a:
      assert property (wr_b && wb_sel_i[1] |=> capture_units_off == $past(wb_dat_i[11:8]))
         else $error("capture bits");
   compare_off_a:
      assert property (wr_b && wb_sel_i[0] |=> compare_units_off == $past(wb_dat_i[3:0]))
         else $error("compare bits");
   read_zero_a:
      assert property (wb_ack_o && !wb_we_i && wb_adr_i == MOD_OFF_SECOND_OFS |->
         wb_dat_o[15:0] == {4'h0, capture_units_off, 4'h0, compare_units_off}) else $error("read");
   reset_clear_a:
      assert property (disable iff (1'b0) rst |=> {can_unit_off, converter_unit_off,
         capture_units_off, compare_units_off} == 10'h000) else $error("reset bits");
   cover property (rej);
   cover property (wr_b);
   cover property ($rose(irq));
endmodule : clk_gate_props
bind clock_source_and_module_gating clk_gate_props chk (.mclk, .rst, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_ack_o, .fast_rc_fail, .can_unit_off, .converter_unit_off, .irq, .wb_adr_i,
   .wb_sel_i, .capture_units_off, .compare_units_off, .wb_dat_i, .wb_dat_o,
   .new_clock_source_select, .current_clock_source);

// *** verification/tb_top.sv ***
// Bench for clock guard and module disable block
`timescale 1ns/10ps
module tb_top;
   import clk_ctrl_pkg::*;
   logic        mclk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, fast_rc_fail = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0, capture_units_off, compare_units_off;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h4f, r;
   logic        wb_ack_o, can_unit_off, converter_unit_off, irq;
   logic [2:0]  new_clock_source_select, current_clock_source;
   logic [31:0] exp_q[$];
   int          n_errors = 0, n_compared = 0;
   wire  [9:0]  offs = {can_unit_off, converter_unit_off, capture_units_off, compare_units_off};
   clock_source_and_module_gating uut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fast_rc_fail, .can_unit_off, .irq,
      .converter_unit_off, .capture_units_off, .compare_units_off,
      .new_clock_source_select, .current_clock_source);
   initial forever #50 mclk = ~mclk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task summarize();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: %h not %h", $time, seen, want);
      end
   endtask : chk
   // Read expectations go to the queue; the monitor compares
   task bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
      int i;
      if (!w) exp_q.push_back({16'h0, e});
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'h3};
      {wb_adr_i, wb_dat_i} <= {a, 16'h0, d};
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         summarize();
      end
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge mclk);
   endtask : bus
   task irq_is(input logic e);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : irq_is
   initial forever begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, exp_q.pop_front());
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      bus(0, MOD_OFF_FIRST_OFS, 16'h0, 16'h0);
      bus(0, MOD_OFF_SECOND_OFS, 16'h0, 16'h0);
      repeat (4) begin
         r = xs();
         bus(1, MOD_OFF_FIRST_OFS, r[15:0], 16'h0);
         bus(1, MOD_OFF_SECOND_OFS, r[31:16], 16'h0);
         chk({22'h0, offs}, {22'h0, r[1:0], r[27:24], r[19:16]});
         bus(0, MOD_OFF_FIRST_OFS, 16'h0, r[15:0] & 16'h0003);
         bus(0, MOD_OFF_SECOND_OFS, 16'h0, r[31:16] & 16'h0f0f);
      end
      $display("disable registers done");
      bus(1, IRQ_MASK_OFS, 16'h0, 16'h0);
      bus(1, OSC_CTRL_OFS, 16'h0300, 16'h0);
      bus(1, OSC_CTRL_OFS, 16'h0400, 16'h0);
      bus(0, OSC_CTRL_OFS, 16'h0, 16'h3300);
      chk({29'h0, new_clock_source_select}, 32'h0000_0003);
      chk({29'h0, current_clock_source}, 32'h0000_0003);
      irq_is(1'b0);
      bus(1, IRQ_MASK_OFS, 16'h3, 16'h0);
      irq_is(1'b1);
      bus(0, IRQ_STATUS_OFS, 16'h0, 16'h2);
      irq_is(1'b0);
      fast_rc_fail <= 1'b1;
      repeat (6) @(posedge mclk);
      chk({29'h0, current_clock_source}, 32'h0000_0004);
      bus(0, OSC_CTRL_OFS, 16'h0, 16'h4300);
      irq_is(1'b1);
      bus(0, IRQ_STATUS_OFS, 16'h0, 16'h1);
      fast_rc_fail <= 1'b0;
      bus(1, 8'h20, 16'hffff, 16'h0);
      bus(0, 8'h20, 16'h0, 16'h0);
      irq_is(1'b0);
      $display("clock source done");
      // Mid-run reset must drop disables that software had set
      bus(1, MOD_OFF_FIRST_OFS, 16'hffff, 16'h0);
      bus(1, MOD_OFF_SECOND_OFS, 16'hffff, 16'h0);
      chk({22'h0, offs}, 32'h0000_03ff);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk({22'h0, offs}, 32'h0000_0000);
      bus(0, MOD_OFF_FIRST_OFS, 16'h0, 16'h0);
      bus(0, MOD_OFF_SECOND_OFS, 16'h0, 16'h0);
      $display("mid-run reset done");
      summarize();
   end
endmodule : tb_top
